// ---- dv/drf_chk.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Port checks
// ------------------------------------------------
module drf_chk
    import drf_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [TERM_N-1:0] term_in,
    input wire logic              panel_run_key,
    input wire logic              panel_mode_toggle_key,
    input wire logic [FREQ_W-1:0] out_freq,
    input wire logic [FREQ_W-1:0] cmd_freq,
    input wire logic              run_active,
    input wire logic              dir_reverse,
    input wire logic              run_led,
    input wire logic              panel_mode_led,
    input wire logic              inching_display
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Windows allow for the two-stage input synchroniser
    both_start_a: assert property ((term_in[1:0] == 2'b11)[*5] |-> cmd_freq == 0)
        else $error("both starts gave a target");
    run_flag_a: assert property (out_freq != 0 |-> ##[0:2] run_active)
        else $error("turning without run flag");
    zero_hold_a: assert property (cmd_freq == 0 && out_freq == 0 |=> out_freq == 0)
        else $error("output left zero without target");
    led_fwd_a: assert property ((out_freq != 0 && !dir_reverse)[*3] |-> run_led)
        else $error("indicator off in forward run");
    led_off_a: assert property ((term_in[1:0] == 0 && !panel_run_key && out_freq == 0)[*5]
        |-> !run_led) else $error("indicator on while stopped");
    jog_led_a: assert property (inching_display |-> panel_mode_led)
        else $error("inching shown without panel light");
    mode_step_a: assert property ($rose(panel_mode_toggle_key)
        |-> ##[1:6] $changed({panel_mode_led, inching_display}))
        else $error("mode unchanged by key");
    jog_run_a: assert property ((inching_display && panel_run_key)[*5] |-> cmd_freq != 0)
        else $error("panel inching without target");
    jog_stop_a: assert property ((inching_display && !panel_run_key)[*5] |-> cmd_freq == 0)
        else $error("panel inching target after release");
    cover property ((term_in[1:0] == 2'b11) && out_freq != 0);
    cover property ($rose(inching_display));
    cover property ($rose(run_led));
endmodule : drf_chk

bind drf_top drf_chk i_chk (.clk, .rst_b, .term_in, .panel_run_key, .panel_mode_toggle_key,
    .out_freq, .cmd_freq, .run_active, .dir_reverse, .run_led, .panel_mode_led, .inching_display);

// ---- dv/drf_sw_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------
// Start switches and panel key
// ------------------------------------------------
module drf_sw_model (
    input  wire logic       clk,
    input  wire logic       fwd,
    input  wire logic       rev,
    input  wire logic       aux,
    input  wire logic       press,
    output logic      [6:0] term,
    output logic            key
);
    logic [2:0] hold_q = 3'h0;
    // Unwired terminals stay open and read low; mode key idle keeps external mode
    assign term = {4'h0, aux, rev, fwd};
    // Key held several cycles so a press survives the synchroniser
    always_ff @(posedge clk) begin
        hold_q <= press ? 3'h7 : hold_q - {2'h0, hold_q != 0};
    end
    assign key = hold_q != 0;
endmodule : drf_sw_model

// ---- dv/drf_top_tb_top.sv ----
`timescale 1ns/1ps
module drf_top_tb_top
    import drf_pkg::*;
;
    logic        clk = 0, rst_b = 0, fwd = 0, rev = 0, aux = 0, press = 0;
    logic        panel_run_key = 0, param_wr = 0, network_variant = 0, panel_mode_toggle_key;
    logic        run_led, panel_mode_led, inching_display;
    logic [3:0]  param_idx = 0;
    logic [15:0] param_data = 0, out_freq, cmd_freq;
    logic [11:0] volt_code = 0, cur_code = 0;
    logic [6:0]  term_in;
    int          miscompares = 0, samples_checked = 0;
    initial forever #2.5 clk = ~clk;
    // Short tick keeps ramps within a few thousand cycles
    drf_top #(.TICK_CYC(20)) i_dut (.clk, .rst_b, .term_in, .network_inching_request(1'b0),
        .network_variant, .panel_run_key, .panel_mode_toggle_key, .volt_code,
        .cur_code, .param_wr, .param_idx, .param_data, .out_freq, .cmd_freq,
        .run_active(), .dir_reverse(), .run_led, .panel_mode_led, .inching_display);
    drf_sw_model i_sw (.clk, .fwd, .rev, .aux, .press, .term(term_in),
        .key(panel_mode_toggle_key));
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task wrap_up;
        $display("checks %0d bad %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task wr_set(input logic [3:0] i, input logic [15:0] d);
        @(posedge clk);
        param_wr <= 1;
        param_idx <= i;
        param_data <= d;
        @(posedge clk);
        param_wr <= 0;
    endtask : wr_set
    // Bounded wait on output (o=1) or target; exhaustion ends the run
    task wt(input string n, input bit o, input logic [15:0] e);
        int k;
        for (k = 0; k < 9000 && (o ? out_freq : cmd_freq) !== e; k++) @(negedge clk);
        chk(n, o ? out_freq : cmd_freq, e);
        if (k == 9000) wrap_up();
    endtask : wt
    task tog;
        @(posedge clk);
        press <= 1;
        @(posedge clk);
        press <= 0;
        repeat (14) @(negedge clk);
    endtask : tog
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        wr_set(IDX_ACCEL_TIME, 16'h000A);
        wr_set(IDX_DECEL_TIME, 16'h000A);
        volt_code <= 12'hFFF;
        fwd <= 1;
        wt("vgain", 0, 16'h1770);
        wt("accel", 1, 16'h1770);
        chk("led", run_led, 1);
        @(posedge clk);
        rev <= 1;
        wt("both", 1, 0);
        $display("test run_both done");
        wr_set(IDX_FUNC_BASE + 4'h2, {8'h00, FN_CUR_SELECT});
        wr_set(IDX_VBIAS_FREQ, 16'h03E8);
        wr_set(IDX_VGAIN_FREQ, 16'h1388);
        rev <= 0;
        aux <= 1;
        cur_code <= 12'hFFF;
        volt_code <= 12'h000;
        wt("cgain", 0, 16'h1770);
        @(posedge clk);
        cur_code <= CUR_4MA_CODE;
        wt("c4ma", 0, 0);
        wr_set(IDX_CBIAS_FREQ, 16'h07D0);
        wt("cbias", 0, 16'h07D0);
        @(posedge clk);
        network_variant <= 1;
        wt("vbias", 0, 16'h03E8);
        @(posedge clk);
        volt_code <= 12'hFFF;
        wt("vgain2", 0, 16'h1388);
        wr_set(IDX_VGAIN_CAL, 16'h0064);
        volt_code <= 12'h032;
        wt("linear", 0, 16'h0BB8);
        @(posedge clk);
        fwd <= 0;
        wt("decel", 1, 0);
        $display("test analog done");
        wr_set(IDX_FUNC_BASE + 4'h2, {8'h00, FN_INCHING});
        network_variant <= 0;
        fwd <= 1;
        wt("inch", 1, 16'h01F4);
        @(posedge clk);
        fwd <= 0;
        wt("inch_stop", 1, 0);
        $display("test inching done");
        repeat (2) tog();
        chk("jog_disp", {15'h0, inching_display}, 1);
        chk("pu_led", {15'h0, panel_mode_led}, 1);
        @(posedge clk);
        panel_run_key <= 1;
        wt("pjog", 1, 16'h01F4);
        @(posedge clk);
        panel_run_key <= 0;
        wt("pjog_stop", 1, 0);
        tog();
        chk("ext", {14'h0, panel_mode_led, inching_display}, 0);
        $display("test panel done");
        wrap_up();
    end
endmodule : drf_top_tb_top

// ---- src/drf_pkg.sv ----
package drf_pkg;

    // ------------------------------------------------------------
    // Units and widths
    // ------------------------------------------------------------
    // Frequencies in 0.01 Hz, ramp times in 0.01 s, analog in ADC codes
    localparam int FREQ_W = 16;
    localparam int TIME_W = 16;
    localparam int ADC_W  = 12;
    localparam int TERM_N = 7;
    localparam int CODE_W = 8;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
    localparam int TICKS_PER_CS = 10;
    localparam int BLINK_W      = 10;
    localparam int BLINK_FAST_BIT = 7;
    localparam int BLINK_SLOW_BIT = 9;

    // ------------------------------------------------------------
    // Analog scaling points
    // ------------------------------------------------------------
    localparam logic [ADC_W-1:0] VOLT_ZERO_CODE = 12'h000;
    localparam logic [ADC_W-1:0] VOLT_FULL_CODE = 12'hFFF;
    localparam logic [ADC_W-1:0] CUR_4MA_CODE   = 12'h333;
    localparam logic [ADC_W-1:0] CUR_20MA_CODE  = 12'hFFF;

    // Ramp times are referred to a 60 Hz swing
    localparam logic [FREQ_W-1:0] RAMP_REF_FREQ = 16'h1770;

    // ------------------------------------------------------------
    // Setting indices on the parameter write port
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_VGAIN_FREQ = 4'h0;
    localparam logic [3:0] IDX_CGAIN_FREQ = 4'h1;
    localparam logic [3:0] IDX_VBIAS_FREQ = 4'h2;
    localparam logic [3:0] IDX_CBIAS_FREQ = 4'h3;
    localparam logic [3:0] IDX_VGAIN_CAL  = 4'h4;
    localparam logic [3:0] IDX_CGAIN_CAL  = 4'h5;
    localparam logic [3:0] IDX_INCH_FREQ  = 4'h6;
    localparam logic [3:0] IDX_INCH_TIME  = 4'h7;
    localparam logic [3:0] IDX_ACCEL_TIME = 4'h8;
    localparam logic [3:0] IDX_DECEL_TIME = 4'h9;
    // Terminal function selections occupy IDX_FUNC_BASE + terminal for terminals 0 to 5; terminal 6 has no index
    localparam logic [3:0] IDX_FUNC_BASE  = 4'hA;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [FREQ_W-1:0] RST_VGAIN_FREQ = 16'h1770;
    localparam logic [FREQ_W-1:0] RST_CGAIN_FREQ = 16'h1770;
    localparam logic [FREQ_W-1:0] RST_VBIAS_FREQ = 16'h0000;
    localparam logic [FREQ_W-1:0] RST_CBIAS_FREQ = 16'h0000;
    localparam logic [ADC_W-1:0]  RST_VGAIN_CAL  = 12'hFFF;
    localparam logic [ADC_W-1:0]  RST_CGAIN_CAL  = 12'hFFF;
    localparam logic [FREQ_W-1:0] RST_INCH_FREQ  = 16'h01F4;
    localparam logic [TIME_W-1:0] RST_INCH_TIME  = 16'h0032;
    localparam logic [TIME_W-1:0] RST_ACCEL_TIME = 16'h01F4;
    localparam logic [TIME_W-1:0] RST_DECEL_TIME = 16'h01F4;

    // ------------------------------------------------------------
    // Input terminal function codes
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] FN_LOW_SPEED   = 8'h00;
    localparam logic [CODE_W-1:0] FN_MID_SPEED   = 8'h01;
    localparam logic [CODE_W-1:0] FN_HIGH_SPEED  = 8'h02;
    localparam logic [CODE_W-1:0] FN_CUR_SELECT  = 8'h04;
    localparam logic [CODE_W-1:0] FN_INCHING     = 8'h05;
    localparam logic [CODE_W-1:0] FN_OUT_STOP    = 8'h18;
    localparam logic [CODE_W-1:0] FN_RESET       = 8'h3E;
    localparam logic [CODE_W-1:0] FN_FWD_START   = 8'h3C;
    localparam logic [CODE_W-1:0] FN_REV_START   = 8'h3D;
    localparam logic [CODE_W-1:0] RST_FUNC [TERM_N] = '{
        FN_FWD_START, FN_REV_START, FN_LOW_SPEED, FN_MID_SPEED,
        FN_HIGH_SPEED, FN_OUT_STOP, FN_RESET};

    // ------------------------------------------------------------
    // Panel operating modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_EXT = 3'b001,
        MODE_PU  = 3'b010,
        MODE_JOG = 3'b100
    } drf_mode_e;

endpackage : drf_pkg

// ---- src/drf_ramp.sv ----
`timescale 1ns/1ps
module drf_ramp
    import drf_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    drf_ramp_if.ramp  rif
);

    // ------------------------------------------------------------
    // Step size per tick
    // ------------------------------------------------------------
    // Remainder is carried so long ramps do not stall on rounding
    logic [31:0]       acc_q;
    logic [31:0]       acc_d;
    logic [31:0]       span;
    logic [31:0]       sum;
    logic [31:0]       step;
    logic [FREQ_W-1:0] freq_q;
    logic [FREQ_W-1:0] freq_d;
    logic              up;

    always_comb begin
        up   = rif.target > freq_q;
        span = 32'(up ? rif.time_up : rif.time_dn) * 32'(TICKS_PER_CS);
        sum  = acc_q + 32'(RAMP_REF_FREQ);
        step = '0;
        acc_d = '0;
        freq_d = freq_q;
        if (rif.target == freq_q) begin
            acc_d = '0;
        end else if (span == '0) begin
            freq_d = rif.target;              // Zero time jumps at once
        end else begin
            step  = sum / span;
            acc_d = sum % span;
            if (up) begin
                freq_d = (32'(rif.target) - 32'(freq_q) <= step) ?
                         rif.target : FREQ_W'(32'(freq_q) + step);
            end else begin
                freq_d = (32'(freq_q) - 32'(rif.target) <= step) ?
                         rif.target : FREQ_W'(32'(freq_q) - step);
            end
        end
    end

    // Advance once per tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q  <= '0;
            freq_q <= '0;
        end else if (rif.tick) begin
            acc_q  <= acc_d;
            freq_q <= freq_d;
        end
    end

    assign rif.freq = freq_q;

endmodule : drf_ramp

// ---- src/drf_ramp_if.sv ----
`timescale 1ns/1ps
interface drf_ramp_if;
    import drf_pkg::*;

    logic              tick;
    logic [FREQ_W-1:0] target;
    logic [TIME_W-1:0] time_up;
    logic [TIME_W-1:0] time_dn;
    logic [FREQ_W-1:0] freq;

    modport ctrl (output tick, output target, output time_up, output time_dn, input freq);
    modport ramp (input tick, input target, input time_up, input time_dn, output freq);

endinterface : drf_ramp_if

// ---- src/drf_scale.sv ----
`timescale 1ns/1ps
module drf_scale
    import drf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADC_W-1:0]  x,
    input  wire logic [ADC_W-1:0]  x_lo,
    input  wire logic [ADC_W-1:0]  x_hi,
    input  wire logic [FREQ_W-1:0] f_lo,
    input  wire logic [FREQ_W-1:0] f_hi,
    output logic      [FREQ_W-1:0] f_q
);

    // ------------------------------------------------------------
    // Straight line from bias point to gain point
    // ------------------------------------------------------------
    // Signed so a gain below bias gives a falling characteristic
    logic signed [47:0] num;
    logic signed [47:0] quo;
    logic        [FREQ_W-1:0] f_d;

    always_comb begin
        num = (48'(signed'({1'b0, f_hi})) - 48'(signed'({1'b0, f_lo})))
              * 48'(signed'({1'b0, x - x_lo}));
        quo = '0;
        if (x <= x_lo) begin
            f_d = f_lo;
        end else if (x >= x_hi || x_hi <= x_lo) begin
            f_d = f_hi;
        end else begin
            quo = num / 48'(signed'({1'b0, x_hi - x_lo}));
            f_d = FREQ_W'(48'(signed'({1'b0, f_lo})) + quo); // R21
        end
    end

    // Registered result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

endmodule : drf_scale

// ---- src/drf_top.sv ----
// Operation
// R1 - Voltage input full scale commands the voltage gain frequency, default 60 Hz.
// R2 - Current input at 20 mA commands the current gain frequency, default 60 Hz.
// R3 - Zero volts commands the voltage bias frequency setting.
// R4 - Current 4 mA point commands the current bias frequency setting.
// R5 - Default calibration: current at or below 4 mA commands zero, motor stops.
// R6 - Current input is frequency source only while current select is on.
// R7 - Terminal function code 4 routes that terminal to current select.
// R8 - Terminal function code 5 routes that terminal to inching request.
// R9 - Network variant: only the first two inputs may carry these functions.
// R10 - Both starts on: no start; if running, decelerate to stop.
// R11 - Start on ramps at acceleration time; off ramps down at deceleration time.
// R12 - Inching needs inching request plus start; uses single inching ramp time.
// R13 - Inching accepted from physical terminals; network inching is separate.
// R14 - Inching frequency resets to 5 Hz and is the inching target.
// R15 - Inching ramp time resets to 0.5 s, for both directions.
// R16 - Run indicator blinks while start is on but command is zero.
// R17 - Indicator on forward, slow blink reverse, off when stopped without start.
// R18 - Panel inching runs only while run key held, else decelerates.
// R19 - Two mode-toggle presses enter panel inching with its indications.
// R20 - Outside party selects external mode before current input or terminal inching.
// R21 - Between bias and gain points the mapping is linear.
`timescale 1ns/1ps
module drf_top
    import drf_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [TERM_N-1:0] term_in,
    input  wire logic              network_inching_request,
    input  wire logic              network_variant,
    input  wire logic              panel_run_key,
    input  wire logic              panel_mode_toggle_key,
    input  wire logic [ADC_W-1:0]  volt_code,
    input  wire logic [ADC_W-1:0]  cur_code,
    input  wire logic              param_wr,
    input  wire logic [3:0]        param_idx,
    input  wire logic [15:0]       param_data,
    output logic      [FREQ_W-1:0] out_freq,
    output logic      [FREQ_W-1:0] cmd_freq,
    output logic                   run_active,
    output logic                   dir_reverse,
    output logic                   run_led,
    output logic                   panel_mode_led,
    output logic                   inching_display
);

    // ------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------
    logic [FREQ_W-1:0] vgain_freq_q;
    logic [FREQ_W-1:0] cgain_freq_q;
    logic [FREQ_W-1:0] vbias_freq_q;
    logic [FREQ_W-1:0] cbias_freq_q;
    logic [ADC_W-1:0]  vgain_cal_q;
    logic [ADC_W-1:0]  cgain_cal_q;
    logic [FREQ_W-1:0] inch_freq_q;
    logic [TIME_W-1:0] inch_time_q;
    logic [TIME_W-1:0] accel_time_q;
    logic [TIME_W-1:0] decel_time_q;
    logic [CODE_W-1:0] func_q [TERM_N];

    // Write port; every setting has a defined reset value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vgain_freq_q <= RST_VGAIN_FREQ;                    // R1
            cgain_freq_q <= RST_CGAIN_FREQ;                    // R2
            vbias_freq_q <= RST_VBIAS_FREQ;
            cbias_freq_q <= RST_CBIAS_FREQ;                    // R5
            vgain_cal_q  <= RST_VGAIN_CAL;
            cgain_cal_q  <= RST_CGAIN_CAL;
            inch_freq_q  <= RST_INCH_FREQ;                     // R14
            inch_time_q  <= RST_INCH_TIME;                     // R15
            accel_time_q <= RST_ACCEL_TIME;
            decel_time_q <= RST_DECEL_TIME;
        end else if (param_wr) begin
            case (param_idx)
                IDX_VGAIN_FREQ: vgain_freq_q <= param_data;
                IDX_CGAIN_FREQ: cgain_freq_q <= param_data;
                IDX_VBIAS_FREQ: vbias_freq_q <= param_data;
                IDX_CBIAS_FREQ: cbias_freq_q <= param_data;
                IDX_VGAIN_CAL:  vgain_cal_q  <= param_data[ADC_W-1:0];
                IDX_CGAIN_CAL:  cgain_cal_q  <= param_data[ADC_W-1:0];
                IDX_INCH_FREQ:  inch_freq_q  <= param_data;
                IDX_INCH_TIME:  inch_time_q  <= param_data;
                IDX_ACCEL_TIME: accel_time_q <= param_data;
                IDX_DECEL_TIME: decel_time_q <= param_data;
                default: ;
            endcase
        end
    end

    // Terminal function selections, one per input terminal
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < TERM_N; i++) begin
                func_q[i] <= RST_FUNC[i];
            end
        end else if (param_wr && param_idx >= IDX_FUNC_BASE) begin
            for (int i = 0; i < TERM_N; i++) begin
                if (param_idx == 4'(IDX_FUNC_BASE + 4'(i))) begin
                    func_q[i] <= param_data[CODE_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [TERM_N-1:0] term_s1_q;
    logic [TERM_N-1:0] term_s2_q;
    logic [1:0]        key_s1_q;
    logic [1:0]        key_s2_q;
    logic              toggle_prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            term_s1_q     <= '0;
            term_s2_q     <= '0;
            key_s1_q      <= '0;
            key_s2_q      <= '0;
            toggle_prev_q <= 1'b0;
        end else begin
            term_s1_q     <= term_in;
            term_s2_q     <= term_s1_q;
            key_s1_q      <= {panel_mode_toggle_key, panel_run_key};
            key_s2_q      <= key_s1_q;
            toggle_prev_q <= key_s2_q[1];
        end
    end

    // ------------------------------------------------------------
    // Terminal function decode
    // ------------------------------------------------------------
    // Network variant has only two physical inputs; the rest are inert
    function automatic logic term_has(input logic [CODE_W-1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < TERM_N; i++) begin
            if (func_q[i] == code && term_s2_q[i] && (!network_variant || i < 2)) begin
                hit = 1'b1;                                    // R9
            end
        end
        return hit;
    endfunction : term_has

    logic fwd_start;
    logic rev_start;
    logic current_input_select;
    logic inching_request;

    always_comb begin
        fwd_start            = term_has(FN_FWD_START);
        rev_start            = term_has(FN_REV_START);
        current_input_select = term_has(FN_CUR_SELECT);          // R7
        inching_request      = term_has(FN_INCHING)              // R8 R13
                               | network_inching_request;
    end

    // ------------------------------------------------------------
    // Panel mode toggling
    // ------------------------------------------------------------
    drf_mode_e mode_q;

    // Each press steps external, panel, panel inching, back to external
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= MODE_EXT;
        end else if (key_s2_q[1] && !toggle_prev_q) begin
            case (mode_q)
                MODE_EXT: mode_q <= MODE_PU;
                MODE_PU:  mode_q <= MODE_JOG;                  // R19
                MODE_JOG: mode_q <= MODE_EXT;
                default:  mode_q <= MODE_EXT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Analog frequency command
    // ------------------------------------------------------------
    logic [FREQ_W-1:0] volt_freq;
    logic [FREQ_W-1:0] cur_freq;

    // Bias at 0 V, gain at the calibrated full-scale code
    drf_scale u_volt (
        .clk   (clk),
        .rst_b (rst_b),
        .x     (volt_code),
        .x_lo  (VOLT_ZERO_CODE),                               // R3
        .x_hi  (vgain_cal_q),                                  // R1
        .f_lo  (vbias_freq_q),
        .f_hi  (vgain_freq_q),
        .f_q   (volt_freq)
    );

    // Bias at 4 mA; at or below it the bias frequency holds
    drf_scale u_cur (
        .clk   (clk),
        .rst_b (rst_b),
        .x     (cur_code),
        .x_lo  (CUR_4MA_CODE),                                 // R4 R5
        .x_hi  (cgain_cal_q),                                  // R2
        .f_lo  (cbias_freq_q),
        .f_hi  (cgain_freq_q),
        .f_q   (cur_freq)
    );

    logic [FREQ_W-1:0] analog_freq;
    assign analog_freq = current_input_select ? cur_freq : volt_freq; // R6

    // ------------------------------------------------------------
    // Tick divider and blink counter
    // ------------------------------------------------------------
    logic [31:0]        tick_cnt_q;
    logic               tick;
    logic [BLINK_W-1:0] blink_q;

    assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_q <= '0;
        end else if (tick) begin
            blink_q <= blink_q + BLINK_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Run command selection
    // ------------------------------------------------------------
    drf_ramp_if rif ();

    logic              ext_mode;
    logic              one_start;
    logic              want_rev;
    logic              dir_rev_q;
    logic              jog_q;
    logic              jog_now;
    logic              panel_jog;
    logic [FREQ_W-1:0] target;
    logic              stopped;

    assign stopped   = (rif.freq == '0);
    assign ext_mode  = (mode_q == MODE_EXT);
    assign one_start = ext_mode && (fwd_start ^ rev_start);   // R10
    assign want_rev  = rev_start;
    assign panel_jog = (mode_q == MODE_JOG) && key_s2_q[0];   // R18

    // Direction only changes at standstill; a reversal ramps down first
    always_comb begin
        target  = '0;
        jog_now = 1'b0;
        if (panel_jog) begin
            target  = dir_rev_q ? '0 : inch_freq_q;            // R18
            jog_now = 1'b1;
        end else if (one_start && inching_request) begin
            target  = (want_rev == dir_rev_q) ? inch_freq_q : '0; // R12 R14
            jog_now = 1'b1;
        end else if (one_start) begin
            target  = (want_rev == dir_rev_q) ? analog_freq : '0; // R11
        end
    end

    // Direction latched when a start is taken from standstill
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_rev_q <= 1'b0;
        end else if (stopped) begin
            if (panel_jog) begin
                dir_rev_q <= 1'b0;
            end else if (one_start) begin
                dir_rev_q <= want_rev;
            end
        end
    end

    // Inching ramp stays in force until the output is back at zero or a start without inching request is taken
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jog_q <= 1'b0;
        end else if (jog_now) begin
            jog_q <= 1'b1;
        end else if (stopped || one_start) begin
            jog_q <= 1'b0;
        end
    end

    assign rif.tick    = tick;
    assign rif.target  = target;
    assign rif.time_up = (jog_now || jog_q) ? inch_time_q : accel_time_q; // R15
    assign rif.time_dn = (jog_now || jog_q) ? inch_time_q : decel_time_q; // R12

    drf_ramp u_ramp (
        .clk   (clk),
        .rst_b (rst_b),
        .rif   (rif.ramp)
    );

    // ------------------------------------------------------------
    // Outputs and indicators
    // ------------------------------------------------------------
    logic start_seen;
    logic led_d;

    assign start_seen = (ext_mode && (fwd_start || rev_start)) || panel_jog;

    always_comb begin
        if (!stopped) begin
            led_d = dir_rev_q ? blink_q[BLINK_SLOW_BIT] : 1'b1; // R17
        end else if (start_seen) begin
            led_d = blink_q[BLINK_FAST_BIT];                    // R16
        end else begin
            led_d = 1'b0;                                       // R17
        end
    end

    // Every visible output from a flip-flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_freq        <= '0;
            cmd_freq        <= '0;
            run_active      <= 1'b0;
            dir_reverse     <= 1'b0;
            run_led         <= 1'b0;
            panel_mode_led  <= 1'b0;
            inching_display <= 1'b0;
        end else begin
            out_freq        <= rif.freq;
            cmd_freq        <= target;
            run_active      <= !stopped || (target != '0);
            dir_reverse     <= dir_rev_q;
            run_led         <= led_d;
            panel_mode_led  <= (mode_q != MODE_EXT);             // R19
            inching_display <= (mode_q == MODE_JOG);             // R19
        end
    end

endmodule : drf_top
